// [rtl/i2c_port_pkg.sv]
/*
 * Shared constants and types for the dual-address two-wire slave port.
 * Assumes a single core clock domain; all bus lines are sampled into it.
 */
package i2c_port_pkg;
    localparam int DATA_W = 8;
    localparam int PTR_W = 8;
    localparam int STRAP_W = 4;
    localparam int SLAVE_ADDR_W = 7;
    localparam int GP_W = 4;
    localparam int GP_FIELD_LSB = 4;
    localparam int MEM_ADDR_W = 9;
    localparam int MEM_DEPTH = 512;
    localparam int SYNC_W = 6;

    // Fixed upper slave-address bits of the OFDM bank
    localparam logic [2:0] OFDM_UPPER_BITS = 3'h2;
    // FEC bank upper bits are not given; value is arbitrary and a top parameter
    localparam logic [2:0] FEC_UPPER_BITS_DEFAULT = 3'h3;

    localparam logic [PTR_W-1:0] GP_REG_OFFSET = 8'h1f;
    localparam logic [PTR_W-1:0] PTR_RESET = 8'h00;
    localparam logic [GP_W-1:0] GP_RESET = 4'h0;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h3f;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_CNT_ONE = 4'h1;
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;

    typedef enum logic {
        BANK_OFDM,
        BANK_FEC
    } bank_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK
    } slave_state_t;
endpackage

// [rtl/i2c_slave_port.sv]
/*
 * Two-wire serial slave port answering two slave addresses, one per bank,
 * with a per-bank auto-incrementing register pointer and four output pins.
 * Assumes the bus master makes the serial clock well below the core clock,
 * so several core cycles fall between serial clock edges.
 */
module i2c_slave_port #(
    parameter logic [2:0] FEC_UPPER_BITS = i2c_port_pkg::FEC_UPPER_BITS_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [i2c_port_pkg::STRAP_W-1:0] address_strap_pins_i,
    output logic [i2c_port_pkg::GP_W-1:0] general_output_pins_o
);
    logic [i2c_port_pkg::SYNC_W-1:0] sync_s;
    logic scl_s;
    logic sda_s;
    logic [i2c_port_pkg::STRAP_W-1:0] strap_s;
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    i2c_port_pkg::slave_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [i2c_port_pkg::DATA_W-1:0] shift_q;
    i2c_port_pkg::bank_t bank_q;
    logic rw_q;
    logic first_q;
    logic master_ack_q;
    logic [i2c_port_pkg::PTR_W-1:0] ptr_q [2];
    logic [i2c_port_pkg::PTR_W-1:0] cur_ptr;
    logic ofdm_hit;
    logic fec_hit;
    logic addr_done;
    logic wr_done;
    logic rd_done;
    logic rd_load;
    logic ack_end;
    logic mem_we_q;
    logic [i2c_port_pkg::MEM_ADDR_W-1:0] mem_waddr_q;
    logic [i2c_port_pkg::DATA_W-1:0] mem_wdata_q;
    logic [i2c_port_pkg::MEM_ADDR_W-1:0] mem_raddr;
    logic [i2c_port_pkg::DATA_W-1:0] mem_rdata;

    // Compares a received address against one bank's address
    function automatic logic addr_match(input logic [6:0] rx, input logic [2:0] upper,
                                        input logic [3:0] strap);
        addr_match = (rx == {upper, strap});
    endfunction

    // Pins come from outside the clock domain: two flops before any use
    line_sync #(
        .W(i2c_port_pkg::SYNC_W),
        .RESET_VAL(i2c_port_pkg::SYNC_RESET)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(en_i),
        .d_i({address_strap_pins_i, scl_i, sda_i}),
        .q_o(sync_s)
    );

    assign strap_s = sync_s[5:2];
    assign scl_s = sync_s[1];
    assign sda_s = sync_s[0];

    // Register storage for both banks
    reg_bank_mem u_mem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(en_i),
        .we_i(mem_we_q),
        .waddr_i(mem_waddr_q),
        .wdata_i(mem_wdata_q),
        .raddr_i(mem_raddr),
        .rdata_o(mem_rdata)
    );

    // Previous line levels for edge detection, taken from synchronised copies
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else if (en_i) begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // Line events; start and stop need the clock high on both samples
    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;
    assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // Address decode against both banks, straps shared by both
    assign ofdm_hit = addr_match(shift_q[7:1], i2c_port_pkg::OFDM_UPPER_BITS, strap_s);
    assign fec_hit = addr_match(shift_q[7:1], FEC_UPPER_BITS, strap_s);

    // Byte-boundary strobes on the falling clock, after the eighth bit or, for ack_end and rd_load, after the acknowledge bit
    assign addr_done = (state_q == i2c_port_pkg::ST_ADDR) && scl_fall
        && (bit_cnt_q == i2c_port_pkg::BITS_PER_BYTE);
    assign wr_done = (state_q == i2c_port_pkg::ST_WR_BYTE) && scl_fall
        && (bit_cnt_q == i2c_port_pkg::BITS_PER_BYTE);
    assign rd_done = (state_q == i2c_port_pkg::ST_RD_BYTE) && scl_fall
        && (bit_cnt_q == i2c_port_pkg::BITS_PER_BYTE);
    assign ack_end = scl_fall && ((state_q == i2c_port_pkg::ST_ADDR_ACK)
        || (state_q == i2c_port_pkg::ST_WR_ACK) || (state_q == i2c_port_pkg::ST_RD_ACK));
    assign rd_load = scl_fall && (((state_q == i2c_port_pkg::ST_ADDR_ACK) && rw_q)
        || ((state_q == i2c_port_pkg::ST_RD_ACK) && master_ack_q));

    // Read address always follows the selected bank's pointer
    assign cur_ptr = ptr_q[bank_q];
    assign mem_raddr = {bank_q, cur_ptr};

    // Transfer sequencer; a start wins in any state, including mid-byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= i2c_port_pkg::ST_IDLE;
        end else if (en_i) begin
            if (start_det) begin
                state_q <= i2c_port_pkg::ST_ADDR;
            end else if (stop_det) begin
                state_q <= i2c_port_pkg::ST_IDLE;
            end else begin
                case (state_q)
                    i2c_port_pkg::ST_IDLE: begin
                        state_q <= i2c_port_pkg::ST_IDLE;
                    end
                    i2c_port_pkg::ST_ADDR: begin
                        if (addr_done) begin
                            if (ofdm_hit || fec_hit) begin
                                state_q <= i2c_port_pkg::ST_ADDR_ACK;
                            end else begin
                                state_q <= i2c_port_pkg::ST_IDLE;
                            end
                        end
                    end
                    i2c_port_pkg::ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            state_q <= rw_q ? i2c_port_pkg::ST_RD_BYTE
                                            : i2c_port_pkg::ST_WR_BYTE;
                        end
                    end
                    i2c_port_pkg::ST_WR_BYTE: begin
                        if (wr_done) begin
                            state_q <= i2c_port_pkg::ST_WR_ACK;
                        end
                    end
                    i2c_port_pkg::ST_WR_ACK: begin
                        if (scl_fall) begin
                            state_q <= i2c_port_pkg::ST_WR_BYTE;
                        end
                    end
                    i2c_port_pkg::ST_RD_BYTE: begin
                        if (rd_done) begin
                            state_q <= i2c_port_pkg::ST_RD_ACK;
                        end
                    end
                    i2c_port_pkg::ST_RD_ACK: begin
                        // A missing acknowledge ends the read; wait for stop or start
                        if (scl_fall) begin
                            state_q <= master_ack_q ? i2c_port_pkg::ST_RD_BYTE
                                                    : i2c_port_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        state_q <= i2c_port_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Bit counter and shift register; input sampled on the rising clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_cnt_q <= i2c_port_pkg::BIT_CNT_ZERO;
            shift_q <= '0;
        end else if (en_i) begin
            if (start_det) begin
                bit_cnt_q <= i2c_port_pkg::BIT_CNT_ZERO;
            end else if (rd_load) begin
                shift_q <= mem_rdata;
                bit_cnt_q <= i2c_port_pkg::BIT_CNT_ONE;
            end else if (ack_end) begin
                bit_cnt_q <= i2c_port_pkg::BIT_CNT_ZERO;
            end else if (scl_rise && ((state_q == i2c_port_pkg::ST_ADDR)
                         || (state_q == i2c_port_pkg::ST_WR_BYTE))) begin
                shift_q <= {shift_q[6:0], sda_s};
                bit_cnt_q <= bit_cnt_q + i2c_port_pkg::BIT_CNT_ONE;
            end else if (scl_fall && (state_q == i2c_port_pkg::ST_RD_BYTE) && !rd_done) begin
                shift_q <= {shift_q[6:0], 1'b0};
                bit_cnt_q <= bit_cnt_q + i2c_port_pkg::BIT_CNT_ONE;
            end
        end
    end

    // Bank, direction and first-byte flag latched per sequence
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_q <= i2c_port_pkg::BANK_OFDM;
            rw_q <= 1'b0;
            first_q <= 1'b0;
        end else if (en_i) begin
            if (addr_done) begin
                bank_q <= fec_hit ? i2c_port_pkg::BANK_FEC : i2c_port_pkg::BANK_OFDM;
                rw_q <= shift_q[0];
                first_q <= 1'b1;
            end else if (wr_done) begin
                first_q <= 1'b0;
            end
        end
    end

    // Master acknowledge sampled on the rising clock of the ack slot
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_ack_q <= 1'b0;
        end else if (en_i) begin
            if (scl_rise && (state_q == i2c_port_pkg::ST_RD_ACK)) begin
                master_ack_q <= ~sda_s;
            end
        end
    end

    // Per-bank pointers: first write byte loads, each data byte advances
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_q[0] <= i2c_port_pkg::PTR_RESET;
            ptr_q[1] <= i2c_port_pkg::PTR_RESET;
        end else if (en_i) begin
            if (wr_done && first_q) begin
                ptr_q[bank_q] <= shift_q;
            end else if (wr_done || rd_done) begin
                ptr_q[bank_q] <= cur_ptr + 8'h01;
            end
        end
    end

    // Registered write port; the pointer advances in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_we_q <= 1'b0;
            mem_waddr_q <= '0;
            mem_wdata_q <= '0;
        end else if (en_i) begin
            mem_we_q <= wr_done && !first_q;
            if (wr_done && !first_q) begin
                mem_waddr_q <= {bank_q, cur_ptr};
                mem_wdata_q <= shift_q;
            end
        end
    end

    // Output pins mirror the top nibble of the FEC register at 1F
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            general_output_pins_o <= i2c_port_pkg::GP_RESET;
        end else if (en_i) begin
            if (wr_done && !first_q && (bank_q == i2c_port_pkg::BANK_FEC)
                && (cur_ptr == i2c_port_pkg::GP_REG_OFFSET)) begin
                general_output_pins_o <= shift_q[i2c_port_pkg::GP_FIELD_LSB +: i2c_port_pkg::GP_W];
            end
        end
    end

    // Data line driver: enable pulls low, changes after a falling clock or on a start or stop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sda_oe_o <= 1'b0;
        end else if (en_i) begin
            if (start_det || stop_det) begin
                sda_oe_o <= 1'b0;
            end else if (addr_done) begin
                sda_oe_o <= ofdm_hit || fec_hit;
            end else if (wr_done) begin
                sda_oe_o <= 1'b1;
            end else if (rd_load) begin
                sda_oe_o <= ~mem_rdata[7];
            end else if (ack_end || rd_done) begin
                sda_oe_o <= 1'b0;
            end else if (scl_fall && (state_q == i2c_port_pkg::ST_RD_BYTE)) begin
                sda_oe_o <= ~shift_q[6];
            end
        end
    end

    // Output levels are constant low; clock enable held off as a pure slave
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sda_o <= 1'b0;
            scl_o <= 1'b0;
            scl_oe_o <= 1'b0;
        end else if (en_i) begin
            sda_o <= 1'b0;
            scl_o <= 1'b0;
            scl_oe_o <= 1'b0;
        end
    end
endmodule

// [rtl/line_sync.sv]
/*
 * Two-flop synchroniser for a group of asynchronous input pins.
 * Assumes each bit is independent; no bus coherence is implied.
 */
module line_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // Only the second stage is visible outside this module
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RESET_VAL;
            q_o <= RESET_VAL;
        end else if (en_i) begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// [rtl/reg_bank_mem.sv]
/*
 * Byte-wide register storage for both banks, bank bit on top of the address.
 * Assumes one write port and one read port; read data come from a register.
 */
module reg_bank_mem (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic we_i,
    input wire logic [i2c_port_pkg::MEM_ADDR_W-1:0] waddr_i,
    input wire logic [i2c_port_pkg::DATA_W-1:0] wdata_i,
    input wire logic [i2c_port_pkg::MEM_ADDR_W-1:0] raddr_i,
    output logic [i2c_port_pkg::DATA_W-1:0] rdata_o
);
    logic [i2c_port_pkg::DATA_W-1:0] mem_q [i2c_port_pkg::MEM_DEPTH];

    // Array has no reset so it maps onto plain RAM
    always_ff @(posedge clk_i) begin
        if (en_i && we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // Registered read; an address change shows one cycle later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (en_i) begin
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule

// [tb/i2c_host_model.sv]
/*
 * Bus master model: pulls the open-drain lines, 160 ns serial clock period.
 * Assumes pull-ups on both wires; the clock stays high between frames.
 */
module i2c_host_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_pull_o,
    output logic sda_pull_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Both lines released while idle
    initial begin
        scl_pull_o = 1'b0;
        sda_pull_o = 1'b0;
    end

    // Quarter of a serial clock period
    task automatic quarter();
        repeat (8) @(posedge clk_i);
    endtask

    // Works from idle and from a held-low clock, so it doubles as repeated start
    task automatic start();
        sda_pull_o <= 1'b0;
        quarter();
        scl_pull_o <= 1'b0;
        quarter();
        sda_pull_o <= 1'b1;
        quarter();
        scl_pull_o <= 1'b1;
        quarter();
    endtask

    // One clock: data set while low, sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        sda_pull_o <= !b;
        quarter();
        scl_pull_o <= 1'b0;
        quarter();
        r = sda_i;
        quarter();
        scl_pull_o <= 1'b1;
        quarter();
    endtask

    // Eight bits then the acknowledge clock; a9 low acknowledges a read byte
    task automatic xfer(input logic [7:0] d, input logic a9, output logic [7:0] r,
                        output logic s9);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(a9, s9);
    endtask

    task automatic stop();
        sda_pull_o <= 1'b1;
        quarter();
        scl_pull_o <= 1'b0;
        quarter();
        sda_pull_o <= 1'b0;
        quarter();
    endtask
endmodule

// [tb/i2c_port_props.sv]
/*
 * Port checker for the dual-address two-wire slave port.
 * Assumes the serial clock phases last far longer than eight core cycles.
 */
module i2c_port_props #(
    parameter logic [2:0] FEC_UPPER_BITS = i2c_port_pkg::FEC_UPPER_BITS_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic [i2c_port_pkg::STRAP_W-1:0] address_strap_pins_i,
    input wire logic [i2c_port_pkg::GP_W-1:0] general_output_pins_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Slave only: the clock pin is never pulled
    scl_release_a: assert property (!scl_oe_o && !scl_o)
        else $error("serial clock line was driven");
    sda_pull_only_a: assert property (!sda_o)
        else $error("data line driven high");
    reset_quiet_a: assert property ($past(rst_i) |-> !sda_oe_o && general_output_pins_o == 4'h0)
        else $error("outputs not quiet after reset");
    // Drive changes land some cycles into a low clock phase, never near a high one
    edge_low_clock_a: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
        else $error("data drive changed near a high clock");
    gp_update_a: assert property ($changed(general_output_pins_o) |-> !scl_i && !$past(scl_i))
        else $error("output pins changed outside a byte end");
    quiet_high_a: assert property (scl_i [*8] |-> $stable(sda_oe_o))
        else $error("data drive moved during a high clock");
    // Start or stop from the master finds the device silent for a while
    start_release_a: assert property ($fell(sda_i) && scl_i && $past(scl_i) |-> !sda_oe_o [*8])
        else $error("device drove data right after a start");
    stop_release_a: assert property ($rose(sda_i) && scl_i && $past(scl_i) |-> !sda_oe_o [*8])
        else $error("device drove data right after a stop");
    ack_hold_a: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
        else $error("data drive dropped too early");
endmodule

bind i2c_slave_port i2c_port_props #(.FEC_UPPER_BITS(FEC_UPPER_BITS)) props (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(en_i),
    .scl_i(scl_i),
    .scl_o(scl_o),
    .scl_oe_o(scl_oe_o),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .address_strap_pins_i(address_strap_pins_i),
    .general_output_pins_o(general_output_pins_o)
);

// [tb/testbench.sv]
/*
 * Self-checking bench for the two-wire slave port with a bus master model.
 * Assumes pull-ups on both wires and a mirror of both register banks here.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] FEC_UP = 3'h3;
    logic clk_i, rst_i, en_i, scl_pull, sda_pull, scl_o, scl_oe_o, sda_o, sda_oe_o;
    logic scl_w, sda_w;
    logic [i2c_port_pkg::STRAP_W-1:0] strap;
    logic [i2c_port_pkg::GP_W-1:0] gp, gp_exp;
    logic [7:0] mem [2][256];
    logic [31:0] seed;
    int fails, num_checks, cycles;

    // Open-drain wires with pull-ups
    assign scl_w = !(scl_oe_o | scl_pull);
    assign sda_w = !(sda_oe_o | sda_pull);

    i2c_slave_port #(.FEC_UPPER_BITS(FEC_UP)) dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(en_i),
        .scl_i(scl_w),
        .scl_o(scl_o),
        .scl_oe_o(scl_oe_o),
        .sda_i(sda_w),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .address_strap_pins_i(strap),
        .general_output_pins_o(gp)
    );
    i2c_host_model host (
        .clk_i(clk_i),
        .sda_i(sda_w),
        .scl_pull_o(scl_pull),
        .sda_pull_o(sda_pull)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = !clk_i;
    end

    // Cut a hang short
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 80000) begin
            fails++;
            conclude();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Slave address byte expected to select a bank
    function automatic logic [7:0] ab(input int bk, input logic rw);
        return {(bk != 0) ? FEC_UP : i2c_port_pkg::OFDM_UPPER_BITS, strap, rw};
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Pointer write plus n data bytes; the caller ends the sequence
    task automatic wr_seq(input int bk, input logic [7:0] p, input int n);
        logic [7:0] r, d;
        logic s;
        host.start();
        host.xfer(ab(bk, 1'b0), 1'b1, r, s);
        check("address ack", 1'b0, s);
        host.xfer(p, 1'b1, r, s);
        check("pointer ack", 1'b0, s);
        for (int k = 0; k < n; k++) begin
            d = 8'(rnd());
            host.xfer(d, 1'b1, r, s);
            check("data ack", 1'b0, s);
            mem[bk][p] = d;
            if (bk == 1 && p == i2c_port_pkg::GP_REG_OFFSET) gp_exp = d[7:4];
            p++;
        end
    endtask

    // Pointer write, repeated start, then n bytes read, the last one refused
    task automatic rd_seq(input int bk, input logic [7:0] p, input int n);
        logic [7:0] r;
        logic s;
        wr_seq(bk, p, 0);
        host.start();
        host.xfer(ab(bk, 1'b1), 1'b1, r, s);
        check("read address ack", 1'b0, s);
        for (int k = 0; k < n; k++) begin
            host.xfer(8'hff, k == n - 1, r, s);
            check("read data", mem[bk][p], r);
            p++;
        end
        repeat (6) @(posedge clk_i);
        check("release after refusal", 1'b0, sda_oe_o);
        host.stop();
    endtask

    initial begin
        logic [7:0] r, a;
        logic s;
        seed = 32'h60;
        en_i = 1'b1;
        rst_i = 1'b1;
        strap = 4'ha;
        gp_exp = 4'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("data drive after reset", 1'b0, sda_oe_o);
        check("outputs after reset", 4'h0, gp);
        check("pin levels after reset", 3'h0, {scl_o, scl_oe_o, sda_o});
        // Pointer wrap in both banks, banks kept apart
        wr_seq(0, 8'hff, 2);
        host.stop();
        wr_seq(1, 8'hff, 2);
        host.stop();
        rd_seq(0, 8'hff, 2);
        rd_seq(1, 8'hff, 2);
        for (int it = 0; it < 5; it++) begin
            strap <= 4'(rnd());
            repeat (4) @(posedge clk_i);
            a = 8'(rnd());
            wr_seq(it % 2, a, 1 + it % 3);
            host.stop();
            rd_seq(it % 2, a, 1 + it % 3);
            // Crossing into the output register from the one below it
            wr_seq(1, 8'h1e, 2);
            host.stop();
            check("general outputs", gp_exp, gp);
            // Foreign addresses are ignored until the next start
            for (int j = 0; j < 2; j++) begin
                host.start();
                a = j ? {3'h5, strap, 1'b0} : {i2c_port_pkg::OFDM_UPPER_BITS, ~strap, 1'b0};
                host.xfer(a, 1'b1, r, s);
                check("foreign address ack", 1'b1, s);
                host.xfer(8'h00, 1'b1, r, s);
                check("ignored byte ack", 1'b1, s);
                host.stop();
            end
        end
        // Frozen core must ignore a whole write to the output register
        en_i <= 1'b0;
        host.start();
        host.xfer(ab(1, 1'b0), 1'b1, r, s);
        check("frozen address ack", 1'b1, s);
        host.xfer(i2c_port_pkg::GP_REG_OFFSET, 1'b1, r, s);
        host.xfer(~{gp_exp, 4'h0}, 1'b1, r, s);
        check("frozen data ack", 1'b1, s);
        host.stop();
        en_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check("frozen outputs", gp_exp, gp);
        check("pin levels at end", 3'h0, {scl_o, scl_oe_o, sda_o});
        conclude();
    end

    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
endmodule
